// [memmap_pkg.sv]
// Shared constants and types of the on-chip memory map decoder.
// Assumes a 100 MHz core clock and one decoder per processor core.
package memmap_pkg;

  // ==========================================================
  // Address spaces, targets and carriers
  typedef enum logic [1:0]
  {
    sp_program = 2'h0,
    sp_data = 2'h1,
    sp_io = 2'h2
  } space_type;

  typedef enum logic [2:0]
  {
    tg_ext = 3'h0,
    tg_rom = 3'h1,
    tg_single_access_ram = 3'h2,
    tg_b0 = 3'h3,
    tg_b1 = 3'h4,
    tg_b2 = 3'h5,
    tg_global = 3'h6
  } target_type;

  typedef struct packed
  {
    logic valid;
    space_type space;
    logic [15:0] addr;
  } request_type;

  typedef struct packed
  {
    logic valid;
    target_type target;
    logic [15:0] offset;
  } route_type;

  // ==========================================================
  // Dual-access blocks, identical on every variant
  localparam logic [15:0] B0_DATA_BASE = 16'h0100;
  localparam logic [15:0] B0_DATA_LAST = 16'h02FF;
  localparam logic [15:0] B0_PROG_BASE = 16'hFE00;
  localparam logic [15:0] B1_DATA_BASE = 16'h0300;
  localparam logic [15:0] B1_DATA_LAST = 16'h04FF;
  localparam logic [15:0] B2_DATA_BASE = 16'h0060;
  localparam logic [15:0] B2_DATA_LAST = 16'h007F;

  // ==========================================================
  // Per-variant ROM and single-access RAM ranges
  // Index: 0 9K RAM, 1 8K ROM, 2 4K ROM, 3 16K ROM, 4 32K ROM, 5 boot with 6K RAM
  localparam int NUM_VARIANTS = 6;
  localparam logic [15:0] ROM_BASE = 16'h0000;
  localparam logic [15:0] ROM_LAST [NUM_VARIANTS] =
    '{16'h07FF, 16'h1FFF, 16'h0FFF, 16'h3FFF, 16'h7FFF, 16'h07FF};
  localparam logic HAS_SINGLE_ACCESS_RAM [NUM_VARIANTS] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  localparam logic [15:0] SA_DATA_BASE = 16'h0800;
  localparam logic [15:0] SA_DATA_LAST [NUM_VARIANTS] =
    '{16'h2BFF, 16'h0BFF, 16'h0800, 16'h13FF, 16'h1FFF, 16'h1FFF};
  localparam logic [15:0] SA_PROG_BASE [NUM_VARIANTS] =
    '{16'h0800, 16'h2000, 16'h0800, 16'h4000, 16'h8000, 16'h8000};
  localparam logic [15:0] SA_PROG_LAST [NUM_VARIANTS] =
    '{16'h2BFF, 16'h23FF, 16'h0800, 16'h4BFF, 16'h97FF, 16'h97FF};
  // Largest single-access block is 2K words
  localparam int SA_BLOCK_SHIFT = 11;

  // ==========================================================
  // Register map (byte addresses) and fields
  localparam logic [11:0] ADDR_MODE = 12'h000;
  localparam logic [11:0] ADDR_ST1 = 12'h004;
  localparam logic [11:0] ADDR_GLOBAL_WINDOW_REG = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam int MODE_ROM_OFF_BIT = 3;
  localparam int MODE_RAM_MAP_BIT = 4;
  localparam int ST1_B0_MAP_BIT = 0;
  localparam int STAT_ROM_ON_BIT = 0;
  localparam int STAT_RAM_PROG_BIT = 1;
  localparam int STAT_B0_PROG_BIT = 2;
  localparam int STAT_EXT_BUSY_BIT = 3;
  localparam int STAT_PEND_LSB = 4;
  localparam int STAT_GLOBAL_WINDOW_REG_LSB = 8;

  // Index 0 mode, 1 status one, 2 global window
  localparam int NUM_CFG = 3;
  localparam logic [15:0] CFG_RESET [NUM_CFG] = '{16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] CFG_MASK [NUM_CFG] = '{16'h0018, 16'h0001, 16'h00FF};
  localparam logic [1:0] CFG_LATENCY_WORDS [NUM_CFG] = '{2'h2, 2'h2, 2'h1};

  // ==========================================================
  // External bus timing
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [1:0] EXT_WRITE_CYCLES = 2'h3;

endpackage : memmap_pkg

// [memory_map_decoder.sv]
// On-chip memory map decoder with APB access to its map registers.
// Assumes the core presents fetch, read and write requests on pclk
// and honours the dummy and stall answers in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module memory_map_decoder #(
  parameter int VARIANT = 0
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rom_disable_select,
  input wire memmap_pkg::request_type fetch_req,
  input wire memmap_pkg::request_type read_req,
  input wire memmap_pkg::request_type write_req,
  output logic fetch_dummy,
  output logic read_stall,
  output logic write_stall,
  output logic ext_busy,
  output memmap_pkg::route_type fetch_route,
  output memmap_pkg::route_type read_route,
  output memmap_pkg::route_type write_route
);

  // ==========================================================
  // Decode functions
  function automatic memmap_pkg::target_type route_of(
    input memmap_pkg::space_type sp,
    input logic [15:0] a,
    input logic rom_on,
    input logic ram_prog,
    input logic b0_prog,
    input logic [7:0] global_window_reg
  );
    memmap_pkg::target_type t;
    t = memmap_pkg::tg_ext;
    if (sp == memmap_pkg::sp_program)
    begin
      if (rom_on && a <= memmap_pkg::ROM_LAST[VARIANT])
        t = memmap_pkg::tg_rom;
      else if (ram_prog && memmap_pkg::HAS_SINGLE_ACCESS_RAM[VARIANT] && a >= memmap_pkg::SA_PROG_BASE[VARIANT]
               && a <= memmap_pkg::SA_PROG_LAST[VARIANT])
        t = memmap_pkg::tg_single_access_ram;
      else if (b0_prog && a >= memmap_pkg::B0_PROG_BASE)
        t = memmap_pkg::tg_b0;
      else
        t = memmap_pkg::tg_ext;
    end
    else if (sp == memmap_pkg::sp_data)
    begin
      if (global_window_reg != 8'h00 && (a[15:8] & global_window_reg) == global_window_reg)
        t = memmap_pkg::tg_global;
      else if (a >= memmap_pkg::B2_DATA_BASE && a <= memmap_pkg::B2_DATA_LAST)
        t = memmap_pkg::tg_b2;
      else if (a >= memmap_pkg::B0_DATA_BASE && a <= memmap_pkg::B0_DATA_LAST && !b0_prog)
        t = memmap_pkg::tg_b0;
      else if (a >= memmap_pkg::B1_DATA_BASE && a <= memmap_pkg::B1_DATA_LAST)
        t = memmap_pkg::tg_b1;
      else if (memmap_pkg::HAS_SINGLE_ACCESS_RAM[VARIANT] && (VARIANT != 0 || !ram_prog)
               && a >= memmap_pkg::SA_DATA_BASE && a <= memmap_pkg::SA_DATA_LAST[VARIANT])
        t = memmap_pkg::tg_single_access_ram;
    end
    return t;
  endfunction : route_of

  function automatic logic [15:0] base_of(
    input memmap_pkg::target_type t,
    input memmap_pkg::space_type sp
  );
    logic [15:0] b;
    b = 16'h0000;
    case (t)
      memmap_pkg::tg_rom: b = memmap_pkg::ROM_BASE;
      memmap_pkg::tg_single_access_ram: b = (sp == memmap_pkg::sp_program) ?
        memmap_pkg::SA_PROG_BASE[VARIANT] : memmap_pkg::SA_DATA_BASE;
      memmap_pkg::tg_b0: b = (sp == memmap_pkg::sp_program) ?
        memmap_pkg::B0_PROG_BASE : memmap_pkg::B0_DATA_BASE;
      memmap_pkg::tg_b1: b = memmap_pkg::B1_DATA_BASE;
      memmap_pkg::tg_b2: b = memmap_pkg::B2_DATA_BASE;
      default: b = 16'h0000;
    endcase
    return b;
  endfunction : base_of

  // ==========================================================
  // APB decode
  logic strap_done;
  wire logic sel_mode = paddr == memmap_pkg::ADDR_MODE;
  wire logic sel_st1 = paddr == memmap_pkg::ADDR_ST1;
  wire logic sel_global_window_reg = paddr == memmap_pkg::ADDR_GLOBAL_WINDOW_REG;
  wire logic sel_status = paddr == memmap_pkg::ADDR_STATUS;
  wire logic addr_ok = sel_mode | sel_st1 | sel_global_window_reg | sel_status;
  wire logic access = psel & penable;
  wire logic setup = psel & ~penable;
  wire logic [2:0] cfg_wr = {3{access & pwrite}} & {sel_global_window_reg, sel_st1, sel_mode};
  wire logic fetch_taken;

  assign pready = 1'b1;
  // Status is read-only; a write to it is flagged rather than dropped silently
  assign pslverr = access & (~addr_ok | (pwrite & sel_status));

  // ==========================================================
  // Map registers: written value waits in a shadow until enough words pass
  genvar g;
  generate
    for (g = 0; g < memmap_pkg::NUM_CFG; g++)
    begin : cfg
      logic [15:0] shadow;
      logic [15:0] applied;
      logic [1:0] cnt;
      logic [15:0] next_shadow;
      logic [15:0] next_applied;
      logic [1:0] next_cnt;
      wire logic cap = (g == 0) && !strap_done;

      always_comb
      begin
        next_shadow = shadow;
        next_applied = applied;
        next_cnt = cnt;
        // Count only words that really advance the program counter
        if (fetch_taken && cnt != 2'h0)
        begin
          next_cnt = cnt - 2'h1;
          if (cnt == 2'h1)
            next_applied = shadow;
        end
        if (cfg_wr[g])
        begin
          next_shadow = pwdata[15:0] & memmap_pkg::CFG_MASK[g];
          next_cnt = memmap_pkg::CFG_LATENCY_WORDS[g];
        end
        if (cap)
        begin
          next_shadow[memmap_pkg::MODE_ROM_OFF_BIT] = rom_disable_select;
          next_applied[memmap_pkg::MODE_ROM_OFF_BIT] = rom_disable_select;
        end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          shadow <= memmap_pkg::CFG_RESET[g];
          applied <= memmap_pkg::CFG_RESET[g];
          cnt <= 2'h0;
        end
        else
        begin
          shadow <= next_shadow;
          applied <= next_applied;
          cnt <= next_cnt;
        end
      end
    end
  endgenerate

  // Pin is taken once, on the first edge after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      strap_done <= 1'b0;
    else
      strap_done <= 1'b1;
  end

  wire logic rom_on = ~cfg[0].applied[memmap_pkg::MODE_ROM_OFF_BIT];
  wire logic ram_prog = cfg[0].applied[memmap_pkg::MODE_RAM_MAP_BIT];
  wire logic b0_prog = cfg[1].applied[memmap_pkg::ST1_B0_MAP_BIT];
  wire logic [7:0] global_window_reg = cfg[2].applied[7:0];

  // ==========================================================
  // Per-request decode
  wire memmap_pkg::target_type fetch_tgt =
    route_of(fetch_req.space, fetch_req.addr, rom_on, ram_prog, b0_prog, global_window_reg);
  wire memmap_pkg::target_type read_tgt =
    route_of(read_req.space, read_req.addr, rom_on, ram_prog, b0_prog, global_window_reg);
  wire memmap_pkg::target_type write_tgt =
    route_of(write_req.space, write_req.addr, rom_on, ram_prog, b0_prog, global_window_reg);
  wire logic [15:0] fetch_off = fetch_req.addr - base_of(fetch_tgt, fetch_req.space);
  wire logic [15:0] read_off = read_req.addr - base_of(read_tgt, read_req.space);
  wire logic [15:0] write_off = write_req.addr - base_of(write_tgt, write_req.space);
  wire logic [2:0] fetch_blk = 3'(fetch_off >> memmap_pkg::SA_BLOCK_SHIFT);
  wire logic [2:0] read_blk = 3'(read_off >> memmap_pkg::SA_BLOCK_SHIFT);
  wire logic [2:0] write_blk = 3'(write_off >> memmap_pkg::SA_BLOCK_SHIFT);

  // Global window and I/O both leave the chip over the one external bus
  wire logic fetch_ext = fetch_req.valid &&
    (fetch_tgt == memmap_pkg::tg_ext || fetch_tgt == memmap_pkg::tg_global);
  wire logic read_ext = read_req.valid &&
    (read_tgt == memmap_pkg::tg_ext || read_tgt == memmap_pkg::tg_global);
  wire logic write_ext = write_req.valid &&
    (write_tgt == memmap_pkg::tg_ext || write_tgt == memmap_pkg::tg_global);
  wire logic fetch_sa = fetch_req.valid && fetch_tgt == memmap_pkg::tg_single_access_ram;
  wire logic read_sa = read_req.valid && read_tgt == memmap_pkg::tg_single_access_ram;
  wire logic write_sa = write_req.valid && write_tgt == memmap_pkg::tg_single_access_ram;
  wire logic sa_rw_clash = read_sa && write_sa && read_blk == write_blk;
  wire logic sa_fetch_clash = fetch_sa &&
    ((read_sa && read_blk == fetch_blk) || (write_sa && write_blk == fetch_blk));

  // ==========================================================
  // External bus arbitration
  logic [1:0] wbus_cnt;
  logic [1:0] next_wbus_cnt;
  wire logic wbusy = wbus_cnt != 2'h0;
  wire logic write_go;
  wire logic ext_now;

  // A write that is already holding the bus outranks new readers
  assign write_stall = (write_ext && wbusy) || sa_rw_clash;
  assign write_go = write_ext && !write_stall;
  assign ext_now = wbusy | write_go;
  assign read_stall = read_ext && ext_now;
  assign fetch_dummy = (fetch_ext && (ext_now || read_ext)) || sa_fetch_clash;
  assign fetch_taken = fetch_req.valid && !fetch_dummy;
  assign ext_busy = ext_now;

  // The write cycle itself is the first of its three bus cycles
  assign next_wbus_cnt = write_go ? memmap_pkg::EXT_WRITE_CYCLES - 2'h1 :
    (wbusy ? wbus_cnt - 2'h1 : 2'h0);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wbus_cnt <= 2'h0;
    else
      wbus_cnt <= next_wbus_cnt;
  end

  // ==========================================================
  // Registered routes to the memory blocks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fetch_route <= '0;
      read_route <= '0;
      write_route <= '0;
    end
    else
    begin
      fetch_route <= {fetch_taken, fetch_tgt, fetch_off};
      read_route <= {read_req.valid && !read_stall, read_tgt, read_off};
      write_route <= {write_req.valid && !write_stall, write_tgt, write_off};
    end
  end

  // ==========================================================
  // Read data
  logic [15:0] status_word;
  always_comb
  begin
    status_word = 16'h0000;
    status_word[memmap_pkg::STAT_ROM_ON_BIT] = rom_on;
    status_word[memmap_pkg::STAT_RAM_PROG_BIT] = ram_prog;
    status_word[memmap_pkg::STAT_B0_PROG_BIT] = b0_prog;
    status_word[memmap_pkg::STAT_EXT_BUSY_BIT] = ext_now;
    status_word[memmap_pkg::STAT_PEND_LSB +: 3] =
      {cfg[2].cnt != 2'h0, cfg[1].cnt != 2'h0, cfg[0].cnt != 2'h0};
    status_word[memmap_pkg::STAT_GLOBAL_WINDOW_REG_LSB +: 8] = global_window_reg;
  end

  wire logic [15:0] rd_value = sel_mode ? cfg[0].shadow :
    sel_st1 ? cfg[1].shadow :
    sel_global_window_reg ? cfg[2].shadow :
    sel_status ? status_word : 16'h0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup && !pwrite)
      prdata <= {16'h0000, rd_value};
  end

  // ==========================================================
  // Checks
  chk_read_beats_fetch: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_ext && read_ext && !ext_now |-> fetch_dummy && !read_stall ##1 !fetch_route.valid)
    else $error("fetch not turned into dummy under read");

  chk_write_three: assert property (@(posedge pclk) disable iff (!presetn)
    write_go |=> wbusy [*2] ##1 !wbusy)
    else $error("external write did not hold bus three cycles");

  chk_fetch_in_write: assert property (@(posedge pclk) disable iff (!presetn)
    wbusy && fetch_ext |-> fetch_dummy ##1 !fetch_route.valid)
    else $error("fetch took bus during external write");

  chk_mode_latency: assert property (@(posedge pclk) disable iff (!presetn)
    cfg[0].cnt == 2'h2 && fetch_taken && !cfg_wr[0]
    |=> cfg[0].cnt == 2'h1 && $stable(cfg[0].applied))
    else $error("mode map applied before two words");

  chk_b0_latency: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_wr[1] |=> cfg[1].cnt == 2'h2 && cfg[1].applied == $past(cfg[1].applied))
    else $error("block zero map changed too early");

  chk_global_window_reg_latency: assert property (@(posedge pclk) disable iff (!presetn)
    cfg[2].cnt == 2'h1 && fetch_taken && !cfg_wr[2] |=> cfg[2].applied == $past(cfg[2].shadow))
    else $error("global window not applied after one word");

  chk_strap_catch: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(strap_done) |-> rom_on == !$past(rom_disable_select))
    else $error("reset strap not captured");

  chk_no_single_access_ram: assert property (@(posedge pclk) disable iff (!presetn)
    memmap_pkg::HAS_SINGLE_ACCESS_RAM[VARIANT] == 1'b0 |-> fetch_route.target != memmap_pkg::tg_single_access_ram
    && read_route.target != memmap_pkg::tg_single_access_ram)
    else $error("single RAM selected on variant without it");

  chk_single_access_ram_prog: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_route.valid && fetch_route.target == memmap_pkg::tg_single_access_ram |-> $past(ram_prog))
    else $error("single RAM in program space without map bit");

  chk_b0_prog: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_route.valid && fetch_route.target == memmap_pkg::tg_b0 |-> $past(b0_prog))
    else $error("block zero in program space without map bit");

  chk_single_access_ram_single: assert property (@(posedge pclk) disable iff (!presetn)
    sa_rw_clash |-> write_stall ##1 !write_route.valid)
    else $error("two accesses to one single-access block");

  chk_dual_both: assert property (@(posedge pclk) disable iff (!presetn)
    read_req.valid && write_req.valid && read_tgt == memmap_pkg::tg_b1 && write_tgt == memmap_pkg::tg_b1
    |=> read_route.valid && write_route.valid)
    else $error("dual block refused read and write together");

  chk_b2_range: assert property (@(posedge pclk) disable iff (!presetn)
    read_req.space == memmap_pkg::sp_data && global_window_reg == 8'h00 && read_req.addr >= memmap_pkg::B2_DATA_BASE
    && read_req.addr <= memmap_pkg::B2_DATA_LAST |-> read_tgt == memmap_pkg::tg_b2)
    else $error("block two range not decoded");

  chk_unmapped_ext: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_req.valid && !rom_on && !ram_prog && !b0_prog |-> fetch_tgt == memmap_pkg::tg_ext)
    else $error("unmapped fetch stayed on chip");

endmodule : memory_map_decoder
`default_nettype wire

// [core_fetch_model.sv]
// Fetch slot of the core pipeline: one program fetch per cycle.
// Assumes the bench loads start_pc while run is low.
`timescale 1ns/100ps
`default_nettype none
module core_fetch_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [15:0] start_pc,
  input wire logic [15:0] step,
  input wire logic fetch_dummy,
  output memmap_pkg::request_type fetch_req
);
  logic [15:0] pc;

  // ==========================================================
  // Program counter, frozen on a dummy slot
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pc <= 16'h0000;
    else if (!run)
      pc <= start_pc;
    else if (!fetch_dummy)
      pc <= pc + step;
  end

  assign fetch_req = '{valid: run, space: memmap_pkg::sp_program, addr: pc};
endmodule : core_fetch_model
`default_nettype wire

// [onchip_memory_map_decoder_test.sv]
// Self-checking bench for the memory map decoder, first variant.
// Assumes the fetch model owns the fetch slot; the bench drives APB and operands.
`timescale 1ns/100ps
`default_nettype none
module onchip_memory_map_decoder_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rom_disable_select, run, err;
  logic fetch_dummy, read_stall, write_stall, ext_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] start_pc, step;
  memmap_pkg::request_type fetch_req, read_req, write_req;
  memmap_pkg::route_type fetch_route, read_route, write_route;
  memmap_pkg::route_type fq [$];
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;

  memory_map_decoder #(.VARIANT(0)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rom_disable_select(rom_disable_select), .fetch_req(fetch_req), .read_req(read_req),
    .write_req(write_req), .fetch_dummy(fetch_dummy), .read_stall(read_stall), .write_stall(write_stall),
    .ext_busy(ext_busy), .fetch_route(fetch_route), .read_route(read_route), .write_route(write_route));
  core_fetch_model core (.pclk(pclk), .presetn(presetn), .run(run), .start_pc(start_pc), .step(step),
    .fetch_dummy(fetch_dummy), .fetch_req(fetch_req));

  // ==========================================================
  // Clock, timeout and fetch route monitor
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      complete_run();
    end
  end
  always @(posedge pclk)
    if (fetch_route.valid === 1'b1)
      fq.push_back(fetch_route);

  // ==========================================================
  // Reporting and comparisons
  task automatic complete_run();
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic fail(input string what);
    n_errors++;
    $display("ERROR %0t %s", $time, what);
  endtask : fail
  task automatic check_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp)
      fail(what);
  endtask : check_bit
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
      fail(what);
  endtask : check_word
  task automatic check_route(input memmap_pkg::route_type got, input memmap_pkg::target_type t,
    input logic [15:0] ofs, input string what);
    checks++;
    if (got.valid !== 1'b1 || got.target !== t || got.offset !== ofs)
      fail(what);
  endtask : check_route
  task automatic check_fq(input memmap_pkg::target_type t, input logic [15:0] ofs);
    if (fq.size() == 0)
      fail("fetch route missing");
    else
      check_route(fq.pop_front(), t, ofs, "fetch route");
  endtask : check_fq

  // ==========================================================
  // Bus and request drivers
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
    input logic exp_err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!wr)
      check_word(rd, exp, "read data");
    check_bit(err, exp_err, "slave error");
  endtask : apb
  task automatic do_read(input memmap_pkg::space_type sp, input logic [15:0] a,
    input memmap_pkg::target_type t, input logic [15:0] ofs);
    @(posedge pclk);
    read_req <= '{1'b1, sp, a};
    @(posedge pclk);
    read_req.valid <= 1'b0;
    @(negedge pclk);
    check_route(read_route, t, ofs, "read route");
  endtask : do_read
  // Runs n taken fetches; dummy slots are retried by the model
  task automatic run_fetch(input logic [15:0] pc, input logic [15:0] st, input int n);
    int k;
    k = 0;
    fq.delete();
    @(posedge pclk);
    start_pc <= pc;
    step <= st;
    @(posedge pclk);
    run <= 1'b1;
    for (int i = 0; i < 50 && k < n; i++)
    begin
      @(negedge pclk);
      if (fetch_dummy === 1'b0)
        k++;
    end
    @(posedge pclk);
    run <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : run_fetch
  task automatic conc(input logic [15:0] ra, input logic [15:0] wa, input logic stall);
    @(posedge pclk);
    read_req <= '{1'b1, memmap_pkg::sp_data, ra};
    write_req <= '{1'b1, memmap_pkg::sp_data, wa};
    @(negedge pclk);
    check_bit(write_stall, stall, "write stall");
    check_bit(read_stall | fetch_dummy, 1'b0, "read or fetch held");
    @(posedge pclk);
    read_req.valid <= 1'b0;
    write_req.valid <= stall;
    @(negedge pclk);
    check_bit(write_stall, 1'b0, "held write");
    check_bit(write_route.valid, ~stall, "write route");
    @(posedge pclk);
    write_req.valid <= 1'b0;
  endtask : conc

  // ==========================================================
  // Scenarios
  task automatic t_reset_values();
    apb(1'b0, memmap_pkg::ADDR_MODE, 0, 32'h0000_0000, 1'b0);
    apb(1'b0, memmap_pkg::ADDR_ST1, 0, 32'h0000_0000, 1'b0);
    apb(1'b0, memmap_pkg::ADDR_STATUS, 0, 32'h0000_0001, 1'b0);
    apb(1'b0, 12'h010, 0, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h010, 32'h0000_FFFF, 0, 1'b1);
    apb(1'b1, memmap_pkg::ADDR_STATUS, 32'h0000_FFFF, 0, 1'b1);
    run_fetch(16'h07FE, 16'h0001, 3);
    check_fq(memmap_pkg::tg_rom, 16'h07FE);
    check_fq(memmap_pkg::tg_rom, 16'h07FF);
    check_fq(memmap_pkg::tg_ext, 16'h0800);
  endtask : t_reset_values
  task automatic t_data_decode();
    logic [15:0] ad [11] = '{16'h0060, 16'h007F, 16'h0080, 16'h0100, 16'h02FF, 16'h0300, 16'h04FF,
      16'h0800, 16'h2BFF, 16'h2C00, 16'h0100};
    logic [15:0] ofs [11] = '{16'h0000, 16'h001F, 16'h0080, 16'h0000, 16'h01FF, 16'h0000, 16'h01FF,
      16'h0000, 16'h23FF, 16'h2C00, 16'h0100};
    memmap_pkg::target_type tg [11] = '{memmap_pkg::tg_b2, memmap_pkg::tg_b2, memmap_pkg::tg_ext,
      memmap_pkg::tg_b0, memmap_pkg::tg_b0, memmap_pkg::tg_b1, memmap_pkg::tg_b1, memmap_pkg::tg_single_access_ram,
      memmap_pkg::tg_single_access_ram, memmap_pkg::tg_ext, memmap_pkg::tg_ext};
    for (int i = 0; i < 11; i++)
      do_read((i == 10) ? memmap_pkg::sp_io : memmap_pkg::sp_data, ad[i], tg[i], ofs[i]);
  endtask : t_data_decode
  task automatic t_concurrent();
    @(posedge pclk);
    start_pc <= 16'h0000;
    step <= 16'h0000;
    @(posedge pclk);
    run <= 1'b1;
    conc(16'h0300, 16'h0400, 1'b0);
    conc(16'h0800, 16'h0900, 1'b1);
    conc(16'h0800, 16'h1000, 1'b0);
    run <= 1'b0;
  endtask : t_concurrent
  task automatic t_read_wins();
    @(posedge pclk);
    start_pc <= 16'h3000;
    step <= 16'h0001;
    @(posedge pclk);
    run <= 1'b1;
    read_req <= '{1'b1, memmap_pkg::sp_data, 16'h4000};
    @(negedge pclk);
    check_bit(fetch_dummy & ~read_stall, 1'b1, "read beats fetch");
    @(posedge pclk);
    read_req.valid <= 1'b0;
    @(negedge pclk);
    check_word({16'h0000, fetch_req.addr}, 32'h0000_3000, "pc held");
    check_route(read_route, memmap_pkg::tg_ext, 16'h4000, "read route");
    @(posedge pclk);
    run <= 1'b0;
  endtask : t_read_wins
  task automatic t_ext_write();
    @(posedge pclk);
    start_pc <= 16'h3000;
    @(posedge pclk);
    run <= 1'b1;
    write_req <= '{1'b1, memmap_pkg::sp_data, 16'h4000};
    for (int i = 0; i < 4; i++)
    begin
      @(negedge pclk);
      check_bit(ext_busy, i < 3, "bus busy");
      check_bit(fetch_dummy, i < 3, "fetch dummy");
      @(posedge pclk);
      write_req.valid <= 1'b0;
      run <= (i < 3);
    end
    @(negedge pclk);
    check_word({16'h0000, fetch_req.addr}, 32'h0000_3001, "pc after write");
  endtask : t_ext_write
  task automatic t_map_changes();
    apb(1'b1, memmap_pkg::ADDR_ST1, 32'h0000_0001, 0, 1'b0);
    run_fetch(16'hFE00, 16'h0000, 3);
    check_fq(memmap_pkg::tg_ext, 16'hFE00);
    check_fq(memmap_pkg::tg_ext, 16'hFE00);
    check_fq(memmap_pkg::tg_b0, 16'h0000);
    apb(1'b1, memmap_pkg::ADDR_ST1, 32'h0000_0000, 0, 1'b0);
    run_fetch(16'hFE00, 16'h0000, 3);
    check_fq(memmap_pkg::tg_b0, 16'h0000);
    check_fq(memmap_pkg::tg_b0, 16'h0000);
    check_fq(memmap_pkg::tg_ext, 16'hFE00);
    apb(1'b1, memmap_pkg::ADDR_ST1, 32'h0000_0001, 0, 1'b0);
    apb(1'b1, memmap_pkg::ADDR_MODE, 32'h0000_0018, 0, 1'b0);
    run_fetch(16'h0000, 16'h0000, 3);
    check_fq(memmap_pkg::tg_rom, 16'h0000);
    check_fq(memmap_pkg::tg_rom, 16'h0000);
    check_fq(memmap_pkg::tg_ext, 16'h0000);
    run_fetch(16'h2BFF, 16'h0001, 2);
    check_fq(memmap_pkg::tg_single_access_ram, 16'h23FF);
    check_fq(memmap_pkg::tg_ext, 16'h2C00);
    apb(1'b0, memmap_pkg::ADDR_MODE, 0, 32'h0000_0018, 1'b0);
    apb(1'b1, memmap_pkg::ADDR_GLOBAL_WINDOW_REG, 32'h0000_0080, 0, 1'b0);
    do_read(memmap_pkg::sp_data, 16'h8000, memmap_pkg::tg_ext, 16'h8000);
    run_fetch(16'h0000, 16'h0000, 1);
    do_read(memmap_pkg::sp_data, 16'h8000, memmap_pkg::tg_global, 16'h8000);
    do_read(memmap_pkg::sp_data, 16'h7F00, memmap_pkg::tg_ext, 16'h7F00);
    apb(1'b0, memmap_pkg::ADDR_STATUS, 0, 32'h0000_8006, 1'b0);
  endtask : t_map_changes
  task automatic t_strap();
    @(posedge pclk);
    presetn <= 1'b0;
    rom_disable_select <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rom_disable_select <= 1'b0;
    apb(1'b0, memmap_pkg::ADDR_MODE, 0, 32'h0000_0008, 1'b0);
    apb(1'b0, memmap_pkg::ADDR_STATUS, 0, 32'h0000_0000, 1'b0);
    run_fetch(16'h0000, 16'h0001, 1);
    check_fq(memmap_pkg::tg_ext, 16'h0000);
  endtask : t_strap

  // ==========================================================
  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rom_disable_select = 1'b0;
    run = 1'b0;
    start_pc = 16'h0000;
    step = 16'h0000;
    read_req = '0;
    write_req = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset_values();
    t_data_decode();
    t_concurrent();
    t_read_wins();
    t_ext_write();
    t_map_changes();
    t_strap();
    complete_run();
  end
endmodule : onchip_memory_map_decoder_test
`default_nettype wire
